// >>> logic/rx_pair_buffer.sv
// small receive buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module rx_pair_buffer #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 2
) (
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_rstn,
	input  wire logic [WIDTH-1:0]         i_data,
	input  wire logic                     i_valid,
	output logic                          o_ready,
	output logic [WIDTH-1:0]              o_data,
	output logic                          o_valid,
	input  wire logic                     i_ready,
	output logic [$clog2(DEPTH):0]        o_level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp;
	logic [AW-1:0]    rp;
	logic [AW:0]      cnt;
	logic [AW-1:0]    next_wp;
	logic [AW-1:0]    next_rp;
	logic [AW:0]      next_cnt;
	logic             push;
	logic             pop;
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
		$error("rx_pair_buffer: DEPTH must be a power of two >= 2");
	end
	assign o_ready = cnt != (AW + 1)'(DEPTH);
	assign o_valid = cnt != '0;
	assign o_data = mem[rp];
	assign o_level = cnt;
	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;
	always_comb begin
		next_wp = wp + AW'(push);
		next_rp = rp + AW'(pop);
		next_cnt = cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wp] <= i_data;
		end
	end
endmodule : rx_pair_buffer
`default_nettype wire

// >>> logic/uart_sleep_baud.sv
// uart channel: apb registers, baud generator, serial engines, sleep control
`timescale 1ns/10ps
`default_nettype none
`include "uart_sleep_defines.svh"
module uart_sleep_baud #(
	parameter int RX_DEPTH = 2
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic [7:0]  i_paddr,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_rx,
	output logic             o_tx,
	input  wire logic [3:0]  i_modem_n,
	output logic             o_asleep
);
	localparam int LW = $clog2(RX_DEPTH) + 1;
	uart_sleep_pkg::uart_st_s st;
	uart_sleep_pkg::uart_st_s next_st;
	uart_sleep_pkg::rx_word_s fifo_data;
	uart_sleep_pkg::rx_word_s hw;
	uart_sleep_pkg::rx_word_s word;
	logic [7:0]    dll;
	logic [7:0]    divisor_high_latch;
	logic [7:0]    next_dll;
	logic [7:0]    next_dlh;
	logic [7:0]    rd_val;
	logic [7:0]    line_status_reg;
	logic [7:0]    m;
	logic [5:0]    iir_code;
	logic [5:0]    sr;
	logic [5:0]    srm1;
	logic [5:0]    half;
	logic [3:0]    fb;
	logic [11:0]   to_limit;
	logic [15:0]   div;
	logic [2:0]    wl_last;
	logic [LW-1:0] fifo_level;
	logic [3:0]    mdm_s1;
	logic [3:0]    mdm_s2;
	logic          rx_s1;
	logic          rx_s2;
	logic          fifo_valid;
	logic          fifo_in_ready;
	logic          hit;
	logic          setup;
	logic          acc;
	logic          wr_en;
	logic          rd_pop;
	logic          wr_data;
	logic          run;
	logic          tick;
	logic          div_zero;
	logic          pre_tick;
	logic          ls_p;
	logic          to_p;
	logic          rxd_p;
	logic          thr_p;
	logic          mdm_p;
	logic          sleep_en;
	logic          idle_ok;
	logic          wake;
	logic          tx_bit_out;

	rx_pair_buffer #(
		.WIDTH($bits(uart_sleep_pkg::rx_word_s)),
		.DEPTH(RX_DEPTH)
	) u_rx_buf (
		.i_clk_sys(i_clk_sys),
		.i_rstn   (i_rstn),
		.i_data   (st.rx_word),
		.i_valid  (st.rx_pend),
		.o_ready  (fifo_in_ready),
		.o_data   (fifo_data),
		.o_valid  (fifo_valid),
		.i_ready  (rd_pop),
		.o_level  (fifo_level)
	);

	// pin synchronisers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			mdm_s1 <= 4'hF;
			mdm_s2 <= 4'hF;
		end else begin
			rx_s1 <= i_rx;
			rx_s2 <= rx_s1;
			mdm_s1 <= i_modem_n;
			mdm_s2 <= mdm_s1;
		end
	end

	assign setup = i_psel & ~i_penable;
	assign acc = i_psel & i_penable & st.pready;
	assign wr_en = acc & i_pwrite & ~st.pslverr;
	assign wr_data = wr_en & (i_paddr == `OFF_DATA);
	assign rd_pop = acc & ~i_pwrite & (i_paddr == `OFF_DATA) & fifo_valid;
	assign run = ~st.asleep;
	assign tick = st.baud_tick & run;
	assign div = {divisor_high_latch, dll};
	assign div_zero = div == 16'h0000;
	assign sr = `SAMPLE_BASE - {2'h0, st.sample_count_reduction} + {2'h0, st.sample_count_extension};
	assign srm1 = sr - 6'h01;
	assign half = sr >> 1;
	assign wl_last = 3'h4 + {1'b0, st.line_control_reg[1:0]};
	assign fb = 4'h7 + {2'h0, st.line_control_reg[1:0]} + {3'h0, st.line_control_reg[`LCR_PAR_EN]}
		+ {3'h0, st.line_control_reg[`LCR_STOP2]};
	assign to_limit = `TO_CHARS * {8'h00, fb} * {6'h00, sr};
	assign pre_tick = ~st.modem_control_reg[`MCR_PRESC] | (st.pre_cnt == `PRESC_LAST);
	assign hw = fifo_valid ? fifo_data : '0;
	assign line_status_reg = {hw.bi | hw.fe | hw.pe | st.oe,
		~st.thr_full & (st.tx_st == uart_sleep_pkg::TX_IDLE),
		~st.thr_full, hw.bi, hw.fe, hw.pe, st.oe, fifo_valid};
	assign ls_p = st.interrupt_enable_reg[`IER_LS] & line_status_reg[7];
	assign to_p = st.interrupt_enable_reg[`IER_RXD] & st.to_flag;
	assign rxd_p = st.interrupt_enable_reg[`IER_RXD] & (fifo_level == LW'(RX_DEPTH));
	assign thr_p = st.interrupt_enable_reg[`IER_THR] & st.thr_int;
	assign mdm_p = st.interrupt_enable_reg[`IER_MDM] & (|st.msr_d);
	assign iir_code = ls_p ? `IIR_LS : to_p ? `IIR_TO : rxd_p ? `IIR_RXD
		: thr_p ? `IIR_THR : mdm_p ? `IIR_MDM : `IIR_NONE;
	assign sleep_en = st.enhanced_feature_reg[`EFR_ENH] & st.interrupt_enable_reg[`IER_SLEEP];
	assign idle_ok = rx_s2 & (st.rx_st == uart_sleep_pkg::RX_IDLE)
		& ~st.thr_full & (st.tx_st == uart_sleep_pkg::TX_IDLE)
		& ~(ls_p | to_p | rxd_p | mdm_p) & ~fifo_valid & ~st.rx_pend;
	assign wake = (rx_s2 ^ st.rx_prev) | (|(mdm_s2 ^ st.mdm_prev)) | wr_data;
	assign m = st.rx_sh;
	assign word.data = m;
	assign word.pe = st.line_control_reg[`LCR_PAR_EN]
		& (st.rx_pbit != (st.line_control_reg[`LCR_EVEN] ? ^m : ~^m));
	assign word.fe = ~rx_s2;
	assign word.bi = ~rx_s2 & ~(|m) & ~st.rx_pbit;
	assign tx_bit_out = (st.tx_st == uart_sleep_pkg::TX_START) ? 1'b0
		: (st.tx_st == uart_sleep_pkg::TX_DATA) ? st.tx_sh[0]
		: (st.tx_st == uart_sleep_pkg::TX_PAR) ? st.tx_par : 1'b1;

	always_comb begin
		hit = 1'b1;
		case (i_paddr)
			`OFF_DATA: rd_val = fifo_data.data;
			`OFF_IER: rd_val = st.interrupt_enable_reg;
			`OFF_IIR: rd_val = {2'h0, iir_code};
			`OFF_LCR: rd_val = st.line_control_reg;
			`OFF_MCR: rd_val = st.modem_control_reg;
			`OFF_LSR: rd_val = line_status_reg;
			`OFF_MSR: rd_val = {~mdm_s2, st.msr_d};
			`OFF_EFR: rd_val = st.enhanced_feature_reg;
			`OFF_DLL: rd_val = dll;
			`OFF_DLH: rd_val = divisor_high_latch;
			`OFF_SCR: rd_val = {4'h0, st.sample_count_reduction};
			`OFF_SAMPLE_COUNT_EXTENSION: rd_val = {4'h0, st.sample_count_extension};
			`OFF_STAT: rd_val = {6'h00, st.tx_st != uart_sleep_pkg::TX_IDLE,
				st.asleep};
			default: begin
				rd_val = 8'h00;
				hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_dll = dll;
		next_dlh = divisor_high_latch;
		if (wr_en && i_paddr == `OFF_DLL) begin
			next_dll = i_pwdata[7:0];
		end
		if (wr_en && i_paddr == `OFF_DLH) begin
			next_dlh = i_pwdata[7:0];
		end
	end
	always_ff @(posedge i_clk_sys) begin
		dll <= next_dll;
		divisor_high_latch <= next_dlh;
	end

	always_comb begin
		next_st = st;
		next_st.baud_tick = 1'b0;
		next_st.pready = setup;
		next_st.pslverr = setup & ~hit;
		next_st.prdata = setup ? {24'h000000, rd_val} : 32'h00000000;
		next_st.rx_prev = rx_s2;
		next_st.mdm_prev = mdm_s2;
		next_st.msr_d = (st.msr_d & ~{4{acc & ~i_pwrite & (i_paddr == `OFF_MSR)}})
			| (mdm_s2 ^ st.mdm_prev);
		if (acc && !i_pwrite && i_paddr == `OFF_LSR) begin
			next_st.oe = 1'b0;
		end
		if (acc && !i_pwrite && i_paddr == `OFF_IIR && iir_code == `IIR_THR) begin
			next_st.thr_int = 1'b0;
		end
		if (wr_en) begin
			case (i_paddr)
				`OFF_DATA: begin
					if (!st.thr_full) begin
						next_st.transmit_holding_reg = i_pwdata[7:0];
						next_st.thr_full = 1'b1;
					end
					next_st.thr_int = 1'b0;
				end
				`OFF_IER: next_st.interrupt_enable_reg = i_pwdata[7:0];
				`OFF_LCR: next_st.line_control_reg = i_pwdata[7:0];
				`OFF_MCR: next_st.modem_control_reg = i_pwdata[7:0];
				`OFF_EFR: next_st.enhanced_feature_reg = i_pwdata[7:0];
				`OFF_SCR: next_st.sample_count_reduction = i_pwdata[3:0];
				`OFF_SAMPLE_COUNT_EXTENSION: next_st.sample_count_extension = i_pwdata[3:0];
				default: ;
			endcase
		end
		if (st.rx_pend && fifo_in_ready) begin
			next_st.rx_pend = 1'b0;
		end
		if (rd_pop) begin
			next_st.to_cnt = 12'h000;
			next_st.to_flag = 1'b0;
		end
		if (run) begin
			next_st.pre_cnt = st.modem_control_reg[`MCR_PRESC] ? st.pre_cnt + 2'h1 : 2'h0;
			if (pre_tick) begin
				if (div_zero) begin
					next_st.div_cnt = 16'h0000;
				end else if (st.div_cnt >= div - 16'h0001) begin
					next_st.div_cnt = 16'h0000;
					next_st.baud_tick = 1'b1;
				end else begin
					next_st.div_cnt = st.div_cnt + 16'h0001;
				end
			end
			if (tick && !rd_pop && fifo_level == LW'(1) && !st.to_flag) begin
				if (st.to_cnt >= to_limit - 12'h001) begin
					next_st.to_flag = 1'b1;
				end else begin
					next_st.to_cnt = st.to_cnt + 12'h001;
				end
			end
			unique case (st.tx_st)
				uart_sleep_pkg::TX_IDLE: begin
					if (st.thr_full) begin
						next_st.tx_sh = st.transmit_holding_reg & (8'hFF >> (3'h7 - wl_last));
						next_st.tx_par = st.line_control_reg[`LCR_EVEN]
							? ^(st.transmit_holding_reg & (8'hFF >> (3'h7 - wl_last)))
							: ~^(st.transmit_holding_reg & (8'hFF >> (3'h7 - wl_last)));
						next_st.thr_full = 1'b0;
						next_st.thr_int = 1'b1;
						next_st.tx_st = uart_sleep_pkg::TX_START;
						next_st.tx_samp = 6'h00;
						next_st.tx_bit = 3'h0;
						next_st.tx_stop2 = st.line_control_reg[`LCR_STOP2];
					end
				end
				uart_sleep_pkg::TX_START,
				uart_sleep_pkg::TX_DATA,
				uart_sleep_pkg::TX_PAR,
				uart_sleep_pkg::TX_STOP: begin
					if (tick && st.tx_samp != srm1) begin
						next_st.tx_samp = st.tx_samp + 6'h01;
					end else if (tick) begin
						next_st.tx_samp = 6'h00;
						if (st.tx_st == uart_sleep_pkg::TX_START) begin
							next_st.tx_st = uart_sleep_pkg::TX_DATA;
						end else if (st.tx_st == uart_sleep_pkg::TX_DATA) begin
							next_st.tx_sh = st.tx_sh >> 1;
							next_st.tx_bit = st.tx_bit + 3'h1;
							if (st.tx_bit == wl_last) begin
								next_st.tx_st = st.line_control_reg[`LCR_PAR_EN]
									? uart_sleep_pkg::TX_PAR : uart_sleep_pkg::TX_STOP;
							end
						end else if (st.tx_st == uart_sleep_pkg::TX_PAR) begin
							next_st.tx_st = uart_sleep_pkg::TX_STOP;
						end else if (st.tx_stop2) begin
							next_st.tx_stop2 = 1'b0;
						end else begin
							next_st.tx_st = uart_sleep_pkg::TX_IDLE;
						end
					end
				end
			endcase
			unique case (st.rx_st)
				uart_sleep_pkg::RX_IDLE: begin
					next_st.rx_armed = rx_s2;
					if (st.rx_armed && !rx_s2) begin
						next_st.rx_st = uart_sleep_pkg::RX_START;
						next_st.rx_samp = 6'h00;
						next_st.rx_sh = 8'h00;
						next_st.rx_bit = 3'h0;
						next_st.rx_pbit = 1'b0;
						next_st.rx_armed = 1'b0;
					end
				end
				uart_sleep_pkg::RX_START: begin
					if (tick && st.rx_samp == half) begin
						next_st.rx_samp = 6'h00;
						next_st.rx_st = rx_s2 ? uart_sleep_pkg::RX_IDLE
							: uart_sleep_pkg::RX_DATA;
					end else if (tick) begin
						next_st.rx_samp = st.rx_samp + 6'h01;
					end
				end
				uart_sleep_pkg::RX_DATA,
				uart_sleep_pkg::RX_PAR,
				uart_sleep_pkg::RX_STOP: begin
					if (tick && st.rx_samp != srm1) begin
						next_st.rx_samp = st.rx_samp + 6'h01;
					end else if (tick) begin
						next_st.rx_samp = 6'h00;
						if (st.rx_st == uart_sleep_pkg::RX_DATA) begin
							next_st.rx_sh[st.rx_bit] = rx_s2;
							next_st.rx_bit = st.rx_bit + 3'h1;
							if (st.rx_bit == wl_last) begin
								next_st.rx_st = st.line_control_reg[`LCR_PAR_EN]
									? uart_sleep_pkg::RX_PAR : uart_sleep_pkg::RX_STOP;
							end
						end else if (st.rx_st == uart_sleep_pkg::RX_PAR) begin
							next_st.rx_pbit = rx_s2;
							next_st.rx_st = uart_sleep_pkg::RX_STOP;
						end else begin
							next_st.to_cnt = 12'h000;
							next_st.to_flag = 1'b0;
							next_st.rx_st = uart_sleep_pkg::RX_IDLE;
							if (st.rx_pend && !fifo_in_ready) begin
								next_st.oe = 1'b1;
							end else begin
								next_st.rx_pend = 1'b1;
								next_st.rx_word = word;
							end
						end
					end
				end
			endcase
		end
		next_st.tx_line = st.line_control_reg[`LCR_BREAK] ? 1'b0 : tx_bit_out;
		next_st.asleep = st.asleep ? (sleep_en & ~wake)
			: (sleep_en & idle_ok & ~wake);
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			st <= '0;
			st.line_control_reg <= `LCR_RST;
			st.tx_st <= uart_sleep_pkg::TX_IDLE;
			st.rx_st <= uart_sleep_pkg::RX_IDLE;
			st.tx_line <= 1'b1;
			st.rx_prev <= 1'b1;
			st.mdm_prev <= 4'hF;
		end else begin
			st <= next_st;
		end
	end

	assign o_prdata = st.prdata;
	assign o_pready = st.pready;
	assign o_pslverr = st.pslverr;
	assign o_tx = st.tx_line;
	assign o_asleep = st.asleep;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	property p_sleep_gate;
		$rose(st.asleep) |-> $past(sleep_en);
	endproperty
	a_sleep_gate: assert property (p_sleep_gate)
		else $error("sleep entered while not enabled");
	property p_sleep_entry;
		$rose(st.asleep) |-> $past(idle_ok);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep entered while busy");
	property p_sleep_rxdata;
		st.asleep |-> !fifo_valid && !st.rx_pend;
	endproperty
	a_sleep_rxdata: assert property (p_sleep_rxdata)
		else $error("asleep with unread receive data");
	property p_freeze;
		st.asleep && $past(st.asleep) |-> $stable(st.div_cnt)
			&& $stable(st.rx_st) && $stable(st.tx_st);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("logic advanced while asleep");
	property p_wake;
		st.asleep && wake |=> !st.asleep;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake after wake event");
	property p_to_restart;
		rd_pop |=> st.to_cnt == 12'h000 && !st.to_flag;
	endproperty
	a_to_restart: assert property (p_to_restart)
		else $error("time-out not restarted by read");
	property p_break_tx;
		st.line_control_reg[`LCR_BREAK] ##1 st.line_control_reg[`LCR_BREAK] |-> !o_tx;
	endproperty
	a_break_tx: assert property (p_break_tx)
		else $error("serial output not low during break");
	property p_div_zero;
		div_zero && $past(div_zero) |-> !st.baud_tick;
	endproperty
	a_div_zero: assert property (p_div_zero)
		else $error("baud tick with zero divisor");
	property p_to_code;
		to_p && !ls_p |-> iir_code == `IIR_TO;
	endproperty
	a_to_code: assert property (p_to_code)
		else $error("time-out not reported with its code");
endmodule : uart_sleep_baud
`default_nettype wire

// >>> pkg/uart_sleep_defines.svh
// register offsets, field positions, reset values and counts of the uart channel
`ifndef UART_SLEEP_DEFINES_SVH
`define UART_SLEEP_DEFINES_SVH
`define OFF_DATA 8'h00
`define OFF_IER 8'h04
`define OFF_IIR 8'h08
`define OFF_LCR 8'h0C
`define OFF_MCR 8'h10
`define OFF_LSR 8'h14
`define OFF_MSR 8'h18
`define OFF_EFR 8'h1C
`define OFF_DLL 8'h20
`define OFF_DLH 8'h24
`define OFF_SCR 8'h28
`define OFF_SAMPLE_COUNT_EXTENSION 8'h2C
`define OFF_STAT 8'h30
`define LCR_RST 8'h1D
`define IER_RXD 0
`define IER_THR 1
`define IER_LS 2
`define IER_MDM 3
`define IER_SLEEP 4
`define EFR_ENH 4
`define LCR_PAR_EN 3
`define LCR_EVEN 4
`define LCR_STOP2 2
`define LCR_BREAK 6
`define MCR_PRESC 7
`define IIR_NONE 6'h01
`define IIR_LS 6'h06
`define IIR_TO 6'h0C
`define IIR_RXD 6'h04
`define IIR_THR 6'h02
`define IIR_MDM 6'h00
`define SAMPLE_BASE 6'h10
`define PRESC_LAST 2'h3
`define TO_CHARS 12'h004
`endif

// >>> pkg/uart_sleep_pkg.sv
// types shared by the uart channel
package uart_sleep_pkg;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_PAR   = 5'h08,
		TX_STOP  = 5'h10
	} tx_state_e;
	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} rx_state_e;
	typedef struct packed {
		logic       bi;
		logic       fe;
		logic       pe;
		logic [7:0] data;
	} rx_word_s;
	typedef struct packed {
		logic [7:0]  interrupt_enable_reg;
		logic [7:0]  line_control_reg;
		logic [7:0]  modem_control_reg;
		logic [7:0]  enhanced_feature_reg;
		logic [3:0]  sample_count_reduction;
		logic [3:0]  sample_count_extension;
		logic [7:0]  transmit_holding_reg;
		logic        thr_full;
		logic        thr_int;
		tx_state_e   tx_st;
		logic [7:0]  tx_sh;
		logic [2:0]  tx_bit;
		logic [5:0]  tx_samp;
		logic        tx_stop2;
		logic        tx_par;
		logic        tx_line;
		rx_state_e   rx_st;
		logic [7:0]  rx_sh;
		logic [2:0]  rx_bit;
		logic [5:0]  rx_samp;
		logic        rx_pbit;
		logic        rx_armed;
		logic        rx_pend;
		rx_word_s    rx_word;
		logic        oe;
		logic [11:0] to_cnt;
		logic        to_flag;
		logic [1:0]  pre_cnt;
		logic [15:0] div_cnt;
		logic        baud_tick;
		logic        asleep;
		logic [3:0]  msr_d;
		logic        rx_prev;
		logic [3:0]  mdm_prev;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} uart_st_s;
endpackage : uart_sleep_pkg

// >>> sim/serial_station.sv
// remote serial station model: frame sender and bit-timed receiver
`timescale 1ns/10ps
`default_nettype none
module serial_station (
	input  wire logic        i_clk_sys,
	input  wire logic        i_tx,
	input  wire logic        i_send,
	input  wire logic        i_brk,
	input  wire logic [7:0]  i_byte,
	input  wire logic [15:0] i_bit,
	output logic             o_rx,
	output logic      [7:0]  o_got,
	output logic      [15:0] o_len
);
	logic [9:0] frame;
	int         i, j, n;
	// sender: start low, lsb first, one stop, idle high
	always @(posedge i_clk_sys) begin
		if (i_send) begin
			frame = {1'h1, i_byte, 1'h0};
			for (i = 0; i < 10; i++) begin
				o_rx <= frame[i];
				repeat (i_bit) @(posedge i_clk_sys);
			end
		end else begin
			o_rx <= ~i_brk;
		end
	end
	// receiver: start length measured, bits sampled mid-bit
	always begin
		@(negedge i_tx);
		n = 0;
		while (i_tx === 1'h0) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		o_len = 16'(n);
		repeat (i_bit / 2) @(posedge i_clk_sys);
		for (j = 0; j < 8; j++) begin
			o_got[j] = i_tx;
			if (j < 7) repeat (i_bit) @(posedge i_clk_sys);
		end
	end
endmodule : serial_station
`default_nettype wire

// >>> sim/uart_sleep_baud_test.sv
// self-checking bench of the uart sleep, break and baud channel
`timescale 1ns/10ps
`default_nettype none
`include "uart_sleep_defines.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
$display("BAD %0t got %h want %h", $time, a, e); end end
`define RD(a, e) begin rw(a, 1'h0, 32'h0); `CHK(rdat, e) end
module uart_sleep_baud_test;
	logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
	logic        rerr, tx, rx, asleep, send, brk;
	logic [7:0]  paddr, sbyte, got;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  modem_n;
	logic [15:0] bitlen, len;
	logic [31:0] tbl [4];
	int          n_fail, n_tests, k, i, tper;
	uart_sleep_baud #(.RX_DEPTH(2)) uut (
		.i_clk_sys(clk_sys), .i_rstn(rstn), .i_paddr(paddr),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_rx(rx), .o_tx(tx),
		.i_modem_n(modem_n), .o_asleep(asleep));
	serial_station station (
		.i_clk_sys(clk_sys), .i_tx(tx), .i_send(send), .i_brk(brk),
		.i_byte(sbyte), .i_bit(bitlen), .o_rx(rx), .o_got(got),
		.o_len(len));
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic rw(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		logic rdy;
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		// take the answer settled, ahead of the edge that samples it
		do begin
			@(negedge clk_sys);
			rdy = pready;
			rdat = prdata;
			rerr = pslverr;
			@(posedge clk_sys);
		end while (rdy !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_sys);
	endtask : rw
	task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
		k = 0;
		do begin
			rw(a, 1'h0, 32'h0);
			k++;
		end while ((rdat & m) !== v && k < 4000);
		`CHK(k < 4000, 1'h1)
	endtask : poll
	task automatic snd(input logic [7:0] b);
		sbyte <= b;
		send <= 1'h1;
		@(posedge clk_sys);
		send <= 1'h0;
		repeat (11 * 32) @(posedge clk_sys);
	endtask : snd
	task automatic test_done;
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_fail++;
		test_done;
	end
	initial begin
		rstn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		send = 1'h0;
		brk = 1'h0;
		sbyte = 8'h00;
		modem_n = 4'hF;
		bitlen = 16'h0020;
		n_fail = 0;
		n_tests = 0;
		// dlh, mcr, scr, sample_count_extension, byte
		tbl = '{32'h0100E04B, 32'h00800033, 32'h0000260F, 32'h00000055};
		repeat (3) @(posedge clk_sys);
		rstn <= 1'h1;
		@(posedge clk_sys);
		`RD(`OFF_LCR, 32'h1D)
		`RD(`OFF_IIR, 32'h1)
		`RD(`OFF_LSR, 32'h60)
		`RD(`OFF_MCR, 32'h0)
		rw(8'h40, 1'h0, 32'h0);
		`CHK(rerr, 1'h1)
		$display("test reset done");
		rw(`OFF_DLL, 1'h1, 32'h2);
		rw(`OFF_LCR, 1'h1, 32'h3);
		for (i = 0; i < 4; i++) begin
			rw(`OFF_DLH, 1'h1, {24'h0, tbl[i][31:24]});
			rw(`OFF_MCR, 1'h1, {24'h0, tbl[i][23:16]});
			rw(`OFF_SCR, 1'h1, {28'h0, tbl[i][15:12]});
			rw(`OFF_SAMPLE_COUNT_EXTENSION, 1'h1, {28'h0, tbl[i][11:8]});
			tper = (tbl[i][23] ? 4 : 1) * {tbl[i][31:24], 8'h02};
			bitlen = 16'(tper * (16 - tbl[i][15:12] + tbl[i][11:8]));
			rw(`OFF_DATA, 1'h1, {24'h0, tbl[i][7:0]});
			poll(`OFF_LSR, 32'h40, 32'h40);
			// start bit may lose up to one tick period to tick phase
			`CHK(int'(len) + tper >= int'(bitlen) && len <= bitlen + 16'h0001, 1'h1)
			`CHK(got, tbl[i][7:0])
		end
		$display("test baud done");
		rw(`OFF_DLL, 1'h1, 32'h0);
		rw(`OFF_DATA, 1'h1, 32'h57);
		repeat (200) @(posedge clk_sys);
		rw(`OFF_LSR, 1'h0, 32'h0);
		`CHK(rdat[6], 1'h0)
		`CHK(got, 8'h55)
		rw(`OFF_DLL, 1'h1, 32'h2);
		poll(`OFF_LSR, 32'h40, 32'h40);
		`CHK(got, 8'h57)
		rstn <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'h1;
		@(posedge clk_sys);
		`RD(`OFF_DLL, 32'h2)
		`RD(`OFF_LCR, 32'h1D)
		rw(`OFF_LCR, 1'h1, 32'h3);
		$display("test divisor done");
		rw(`OFF_IER, 1'h1, 32'h1);
		snd(8'hA7);
		`RD(`OFF_IIR, 32'h1)
		repeat (4 * 10 * 32) @(posedge clk_sys);
		`RD(`OFF_IIR, 32'h0C)
		`RD(`OFF_DATA, 32'hA7)
		`RD(`OFF_IIR, 32'h1)
		$display("test timeout done");
		for (i = 0; i < 4; i++) snd(8'h11 + 8'(i));
		`RD(`OFF_IIR, 32'h4)
		rw(`OFF_LSR, 1'h0, 32'h0);
		`CHK(rdat[1:0], 2'h3)
		for (i = 0; i < 3; i++) `RD(`OFF_DATA, 32'h11 + i)
		`RD(`OFF_LSR, 32'h60)
		$display("test buffer done");
		rw(`OFF_LCR, 1'h1, 32'h43);
		repeat (100) @(posedge clk_sys);
		`CHK(tx, 1'h0)
		rw(`OFF_LCR, 1'h1, 32'h3);
		repeat (2) @(posedge clk_sys);
		`CHK(tx, 1'h1)
		brk <= 1'h1;
		repeat (12 * 32) @(posedge clk_sys);
		brk <= 1'h0;
		poll(`OFF_LSR, 32'h1, 32'h1);
		`CHK(rdat[4], 1'h1)
		`RD(`OFF_DATA, 32'h0)
		$display("test break done");
		rw(`OFF_IER, 1'h1, 32'h10);
		repeat (20) @(posedge clk_sys);
		`CHK(asleep, 1'h0)
		rw(`OFF_EFR, 1'h1, 32'h10);
		poll(`OFF_STAT, 32'h1, 32'h1);
		rw(`OFF_DATA, 1'h1, 32'h35);
		repeat (2) @(posedge clk_sys);
		`CHK(asleep, 1'h0)
		poll(`OFF_STAT, 32'h1, 32'h1);
		`CHK(got, 8'h35)
		snd(8'hA9);
		`CHK(asleep, 1'h0)
		`RD(`OFF_DATA, 32'hA9)
		poll(`OFF_STAT, 32'h1, 32'h1);
		modem_n <= 4'hE;
		k = 0;
		while (asleep !== 1'h0 && k < 10) begin
			@(posedge clk_sys);
			k++;
		end
		`CHK(k < 10, 1'h1)
		$display("test sleep done");
		test_done;
	end
endmodule : uart_sleep_baud_test
`default_nettype wire
